// [core/rre_exec.sv]
// Execution of subroutine return and the two rotate-through-carry instructions
`timescale 1ns/1ps
`default_nettype none
`include "rre_defs.svh"

// Functional notes
// - Return word pops the return stack once, in Q4 of its first cycle.
// - Return loads the program counter from stack_head; no status flag changes.
// - Return takes two cycles; second cycle is all no-op, flushing the fetched word.
// - Left rotate writes accumulator when select bit is 0, else the register.
// - Right rotate shifts register toward LSB through carry; same destination select.
module rre_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic [13:0] instrWord,
  input wire logic [12:0] stackHead,
  input wire logic carryFlag,
  input wire logic [7:0] regRdData,
  output var rre_pkg::rre_phase_e phase,
  output var rre_pkg::rre_ret_s ret,
  output var rre_pkg::rre_wr_s wr,
  output logic flush,
  output logic regRead,
  output logic [6:0] regAddr
);

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  rre_phase_gen u_phase (
    .clock(clock),
    .rst(rst),
    .phase(phase)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic rre_pkg::rre_op_e decodeWord(input logic [13:0] word);
    rre_pkg::rre_op_e op;
    op = rre_pkg::RRE_NONE;
    if (word == `RRE_RETURN_WORD) begin
      op = rre_pkg::RRE_RET;
    end else if (word[`RRE_OPCODE_MSB:`RRE_OPCODE_LSB] == `RRE_ROTL_OPCODE) begin
      op = rre_pkg::RRE_ROTL;
    end else if (word[`RRE_OPCODE_MSB:`RRE_OPCODE_LSB] == `RRE_ROTR_OPCODE) begin
      op = rre_pkg::RRE_ROTR;
    end
    return op;
  endfunction : decodeWord

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  rre_pkg::rre_op_e op;
  rre_pkg::rre_op_e next_op;
  logic dest;
  logic next_dest;
  logic [7:0] srcData;
  logic [7:0] next_srcData;
  logic [6:0] next_regAddr;
  logic next_regRead;
  logic next_flush;
  rre_pkg::rre_ret_s next_ret;
  rre_pkg::rre_wr_s next_wr;
  rre_pkg::rre_op_e decoded;
  logic isRotate;

  assign decoded = decodeWord(instrWord);
  assign isRotate = (decoded == rre_pkg::RRE_ROTL) || (decoded == rre_pkg::RRE_ROTR);

  always_comb begin
    next_op = op;
    next_dest = dest;
    next_srcData = srcData;
    next_regAddr = regAddr;
    next_regRead = 1'b0;
    next_flush = 1'b0;
    next_ret = ret;
    next_ret.pop = 1'b0;
    next_ret.pcLoad = 1'b0;
    next_wr = wr;
    next_wr.toAcc = 1'b0;
    next_wr.toReg = 1'b0;
    next_wr.toCarry = 1'b0;
    unique case (phase)
      rre_pkg::RRE_Q1: begin
        if (op == rre_pkg::RRE_RET) begin
          // Fetched word is discarded while the return drains
          next_op = rre_pkg::RRE_FLUSH;
          next_flush = 1'b1;
        end else begin
          next_op = decoded;
          if (isRotate) begin
            next_regAddr = instrWord[`RRE_FADDR_MSB:`RRE_FADDR_LSB];
            next_dest = instrWord[`RRE_DEST_BIT];
            next_regRead = 1'b1;
          end
        end
      end
      rre_pkg::RRE_Q2: begin
        if (op == rre_pkg::RRE_ROTL || op == rre_pkg::RRE_ROTR) begin
          next_srcData = regRdData;
        end
        next_flush = (op == rre_pkg::RRE_FLUSH);
      end
      rre_pkg::RRE_Q3: begin
        next_flush = (op == rre_pkg::RRE_FLUSH);
        if (op == rre_pkg::RRE_RET) begin
          next_ret.pop = 1'b1;
          next_ret.pcLoad = 1'b1;
          next_ret.pcValue = stackHead;
        end else if (op == rre_pkg::RRE_ROTL) begin
          {next_wr.carry, next_wr.data} = {srcData, carryFlag};
          next_wr.toAcc = ~dest;
          next_wr.toReg = dest;
          next_wr.toCarry = 1'b1;
        end else if (op == rre_pkg::RRE_ROTR) begin
          {next_wr.data, next_wr.carry} = {carryFlag, srcData};
          next_wr.toAcc = ~dest;
          next_wr.toReg = dest;
          next_wr.toCarry = 1'b1;
        end
      end
      rre_pkg::RRE_Q4: begin
        next_flush = (op == rre_pkg::RRE_RET);
      end
      default: begin
        next_op = rre_pkg::RRE_NONE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      op <= rre_pkg::RRE_NONE;
      dest <= 1'b0;
      srcData <= `RRE_RST_DATA;
      regAddr <= `RRE_RST_ADDR;
      regRead <= 1'b0;
      flush <= 1'b0;
      ret <= '{pop: 1'b0, pcLoad: 1'b0, pcValue: `RRE_RST_PC};
      wr <= '{toAcc: 1'b0, toReg: 1'b0, toCarry: 1'b0, data: `RRE_RST_DATA, carry: 1'b0};
    end else begin
      op <= next_op;
      dest <= next_dest;
      srcData <= next_srcData;
      regAddr <= next_regAddr;
      regRead <= next_regRead;
      flush <= next_flush;
      ret <= next_ret;
      wr <= next_wr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_flushCycle;
    flush [*4] ##1 !flush;
  endsequence

  sequence s_rotWrite;
    ##2 (wr.toCarry && (wr.toAcc || wr.toReg));
  endsequence

  a_pop_in_q4: assert property (@(posedge clock) disable iff (rst)
    ret.pop |-> phase == rre_pkg::RRE_Q4 && op == rre_pkg::RRE_RET && $past(ret.pop) == 1'b0)
    else $error("stack pop outside Q4 of a return");

  a_pc_from_head: assert property (@(posedge clock) disable iff (rst)
    ret.pop |-> ret.pcLoad && ret.pcValue == $past(stackHead) && !wr.toCarry)
    else $error("program counter not loaded from stack head");

  a_ret_flush: assert property (@(posedge clock) disable iff (rst)
    ret.pop |=> s_flushCycle)
    else $error("second return cycle not flushed for four phases");

  a_flush_quiet: assert property (@(posedge clock) disable iff (rst)
    flush |-> !regRead && !wr.toAcc && !wr.toReg && !wr.toCarry && !ret.pop)
    else $error("activity during flush cycle");

  a_dest_select: assert property (@(posedge clock) disable iff (rst)
    wr.toCarry |-> (wr.toAcc != wr.toReg) && wr.toReg == dest)
    else $error("rotate destination does not follow select bit");

  a_rotl_value: assert property (@(posedge clock) disable iff (rst)
    (wr.toCarry && op == rre_pkg::RRE_ROTL) |-> {wr.carry, wr.data} == {srcData, $past(carryFlag)})
    else $error("left rotate result wrong");

  a_rotr_value: assert property (@(posedge clock) disable iff (rst)
    (wr.toCarry && op == rre_pkg::RRE_ROTR) |-> {wr.data, wr.carry} == {$past(carryFlag), srcData})
    else $error("right rotate result wrong");

  a_rot_one_cycle: assert property (@(posedge clock) disable iff (rst)
    regRead |-> phase == rre_pkg::RRE_Q2 ##0 s_rotWrite)
    else $error("rotate did not write in Q4 of its cycle");

  // Gap after a pop: the flushed cycle and the next decode cannot pop again
  sequence s_popGap;
    !ret.pop [*7];
  endsequence

  a_pop_single: assert property (@(posedge clock) disable iff (rst)
    ret.pop |=> s_popGap)
    else $error("return stack popped more than once");

  a_ret_no_write: assert property (@(posedge clock) disable iff (rst)
    ret.pcLoad |-> !wr.toAcc && !wr.toReg && !regRead)
    else $error("return wrote a data destination");

  a_read_address: assert property (@(posedge clock) disable iff (rst)
    regRead |-> regAddr == $past(instrWord[`RRE_FADDR_MSB:`RRE_FADDR_LSB]))
    else $error("register address not taken from the decoded word");

  a_carry_only: assert property (@(posedge clock) disable iff (rst)
    (wr.toAcc || wr.toReg) |-> wr.toCarry && !ret.pcLoad)
    else $error("destination write without carry update");

endmodule : rre_exec

`default_nettype wire

// [core/rre_defs.svh]
// Constants for the return and rotate execution block
`ifndef RRE_DEFS_SVH
`define RRE_DEFS_SVH

// ----------------------------------------------------------------
// Phase codes, one-hot, one instruction cycle = four clocks
// ----------------------------------------------------------------
`define RRE_PHASE_Q1 4'h1
`define RRE_PHASE_Q2 4'h2
`define RRE_PHASE_Q3 4'h4
`define RRE_PHASE_Q4 4'h8
`define RRE_PHASES_PER_CYCLE 4
`define RRE_RET_CYCLES 2

// ----------------------------------------------------------------
// Operation codes, one-hot
// ----------------------------------------------------------------
`define RRE_OP_NONE 5'h01
`define RRE_OP_RET 5'h02
`define RRE_OP_FLUSH 5'h04
`define RRE_OP_ROTL 5'h08
`define RRE_OP_ROTR 5'h10

// ----------------------------------------------------------------
// Instruction word encodings and fields
// ----------------------------------------------------------------
`define RRE_RETURN_WORD 14'h0008
`define RRE_ROTL_OPCODE 6'h0D
`define RRE_ROTR_OPCODE 6'h0C
`define RRE_OPCODE_MSB 13
`define RRE_OPCODE_LSB 8
`define RRE_DEST_BIT 7
`define RRE_FADDR_MSB 6
`define RRE_FADDR_LSB 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RRE_RST_PC 13'h0000
`define RRE_RST_DATA 8'h00
`define RRE_RST_ADDR 7'h00

`endif

// [core/rre_pkg.sv]
// Types shared by the return and rotate execution block
`include "rre_defs.svh"

package rre_pkg;

  typedef enum logic [3:0] {
    RRE_Q1 = `RRE_PHASE_Q1,
    RRE_Q2 = `RRE_PHASE_Q2,
    RRE_Q3 = `RRE_PHASE_Q3,
    RRE_Q4 = `RRE_PHASE_Q4
  } rre_phase_e;

  typedef enum logic [4:0] {
    RRE_NONE = `RRE_OP_NONE,
    RRE_RET = `RRE_OP_RET,
    RRE_FLUSH = `RRE_OP_FLUSH,
    RRE_ROTL = `RRE_OP_ROTL,
    RRE_ROTR = `RRE_OP_ROTR
  } rre_op_e;

  // Return path towards stack and program counter
  typedef struct packed {
    logic pop;
    logic pcLoad;
    logic [12:0] pcValue;
  } rre_ret_s;

  // Rotate result towards accumulator, register file and carry
  typedef struct packed {
    logic toAcc;
    logic toReg;
    logic toCarry;
    logic [7:0] data;
    logic carry;
  } rre_wr_s;

endpackage : rre_pkg

// [core/rre_phase_gen.sv]
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module rre_phase_gen (
  input wire logic clock,
  input wire logic rst,
  output var rre_pkg::rre_phase_e phase
);

  rre_pkg::rre_phase_e next_phase;

  always_comb begin
    unique case (phase)
      rre_pkg::RRE_Q1: next_phase = rre_pkg::RRE_Q2;
      rre_pkg::RRE_Q2: next_phase = rre_pkg::RRE_Q3;
      rre_pkg::RRE_Q3: next_phase = rre_pkg::RRE_Q4;
      rre_pkg::RRE_Q4: next_phase = rre_pkg::RRE_Q1;
      default: next_phase = rre_pkg::RRE_Q1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= rre_pkg::RRE_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  a_phase_order: assert property (@(posedge clock) disable iff (rst)
    phase == rre_pkg::RRE_Q4 |=> phase == rre_pkg::RRE_Q1)
    else $error("phase did not wrap from Q4 to Q1");

endmodule : rre_phase_gen

`default_nettype wire

// [sim/rre_prog_mem.sv]
// Program memory model that feeds fetched words to the execution block
`timescale 1ns/1ps
`default_nettype none

module rre_prog_mem (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] phase,
  input wire logic pcLoad,
  input wire logic [12:0] pcValue,
  output logic [13:0] instrWord
);
  logic [13:0] mem [0:15];
  logic [12:0] pc;

  // Fetch lands at the end of Q4, so a return leaves one stale word in flight
  always @(posedge clock) begin
    if (rst) begin
      pc <= 13'h0000;
      instrWord <= 14'h0000;
    end else if (phase == 4'h8) begin
      instrWord <= mem[pc[3:0]];
      pc <= pcLoad ? pcValue : pc + 13'h0001;
    end
  end
endmodule : rre_prog_mem

`default_nettype wire

// [sim/tb.sv]
// Self-checking testbench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock, rst, carryFlag;
  logic [12:0] stackHead;
  logic [7:0] regRdData;
  logic [7:0] regFileData;
  logic [13:0] instrWord;
  logic flush, regRead;
  logic [6:0] regAddr;
  logic [3:0] popPhase;
  rre_pkg::rre_phase_e phase;
  rre_pkg::rre_ret_s ret;
  rre_pkg::rre_wr_s wr;
  int mismatches, checksDone, popCnt, loadCnt, flushClk, accCnt, regCnt, carryCnt, readCnt;

  rre_exec rre_exec_i (.clock(clock), .rst(rst), .instrWord(instrWord), .stackHead(stackHead),
    .carryFlag(carryFlag), .regRdData(regRdData), .phase(phase), .ret(ret), .wr(wr),
    .flush(flush), .regRead(regRead), .regAddr(regAddr));
  rre_prog_mem rre_prog_mem_i (.clock(clock), .rst(rst), .phase(phase), .pcLoad(ret.pcLoad),
    .pcValue(ret.pcValue), .instrWord(instrWord));

  // Register file answers only while the read strobe stands
  assign regRdData = regRead ? regFileData : 8'h00;

  always #20 clock = ~clock;

  // ------------------------------
  // Strobe monitor
  // ------------------------------
  always @(posedge clock) begin
    if (!rst) begin
      popCnt += ret.pop;
      loadCnt += ret.pcLoad;
      flushClk += flush;
      accCnt += wr.toAcc;
      regCnt += wr.toReg;
      carryCnt += wr.toCarry;
      readCnt += regRead;
      if (ret.pop === 1'b1) popPhase = phase;
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Loads a program under reset, then runs it
  task automatic run(input logic [13:0] w0, input logic [13:0] w1, input logic [13:0] w3);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    for (int i = 0; i < 16; i++) rre_prog_mem_i.mem[i] = 14'h0000;
    rre_prog_mem_i.mem[0] = w0;
    rre_prog_mem_i.mem[1] = w1;
    rre_prog_mem_i.mem[3] = w3;
    {popCnt, loadCnt, flushClk, accCnt, regCnt, carryCnt, readCnt} = '0;
    popPhase = 4'h0;
    rst <= 1'b0;
    repeat (40) @(posedge clock);
  endtask : run

  task automatic test_rotl();
    regFileData <= 8'hE6;
    carryFlag <= 1'b1;
    run(14'h0D22, 14'h0DA2, 14'h0000);
    check("acc writes", 16'h0001, accCnt);
    check("reg writes", 16'h0001, regCnt);
    check("carry writes", 16'h0002, carryCnt);
    check("reads", 16'h0002, readCnt);
    check("data", 16'h00CD, wr.data);
    check("carry", 16'h0001, wr.carry);
    check("address", 16'h0022, regAddr);
    check("pops", 16'h0000, popCnt);
    $display("test rotl done");
  endtask : test_rotl

  task automatic test_rotr();
    regFileData <= 8'hE6;
    carryFlag <= 1'b1;
    run(14'h0CFF, 14'h0009, 14'h0000);
    check("reg writes", 16'h0001, regCnt);
    check("reads", 16'h0001, readCnt);
    check("acc writes", 16'h0000, accCnt);
    check("data", 16'h00F3, wr.data);
    check("carry", 16'h0000, wr.carry);
    check("address", 16'h007F, regAddr);
    check("pops", 16'h0000, popCnt);
    $display("test rotr done");
  endtask : test_rotr

  task automatic test_return();
    stackHead <= 13'h0003;
    regFileData <= 8'h81;
    carryFlag <= 1'b0;
    run(14'h0008, 14'h0D85, 14'h0C11);
    check("pops", 16'h0001, popCnt);
    check("pop phase", 16'h0008, popPhase);
    check("pc loads", 16'h0001, loadCnt);
    check("pc value", 16'h0003, ret.pcValue);
    check("flush clocks", 16'h0004, flushClk);
    check("reg writes", 16'h0000, regCnt);
    check("reads", 16'h0001, readCnt);
    check("acc writes", 16'h0001, accCnt);
    check("carry writes", 16'h0001, carryCnt);
    check("data", 16'h0040, wr.data);
    check("carry", 16'h0001, wr.carry);
    check("address", 16'h0011, regAddr);
    $display("test return done");
  endtask : test_return

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    stackHead = 13'h0000;
    carryFlag = 1'b0;
    regFileData = 8'h00;
    @(posedge clock);
    test_rotl();
    test_rotr();
    test_return();
    end_sim();
  end

  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
endmodule : tb

`default_nettype wire
